// File: tlw_crate_end.sv
// Crate end: word decoder, status return, latency probe and clock selection
//
// Summary of operation
// - Lane one: trigger words in, status out
// - Pipeline clock arrives on lane two
// - Sync line arrives on lane three
// - Return lanes two and three stay idle
// - Standard mode times lane-four loopback pulse
// - Local master loops lane four back
// - Exactly one pipeline clock source selected
// - Switch picks sources; software may override
// - Route two backplane clocks per slot
// - Supply derived clock to legacy converters
// - One 16-bit word per frame
// - Status words return on reverse direction
// - Strobe word fires prompt trigger output
// - Strobe quadrant places trigger finely
// - Sender keeps strobe latency fixed
// - Content words fill frames without strobes
// - Strobe and content paired by arrival
// - Control words fill otherwise empty frames
// - Idle frames carry master time bits
// - Time mismatch flags lost synchronisation
// - Bits 13:12 select the word type
// - Status bit 15 parity, 14:12 zero
// - Status bits: busy, acks, block, readout
`timescale 1ns/1ps
`default_nettype none
`include "tlw_params.svh"

////////////////////////////////////////////////////////////////////////////////
module tlw_crate_end import tlw_pkg::*; #(
    parameter int LAT_W = 12
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    tlw_link_if.crate link,
    input wire logic [7:0] clk_switch_i,
    input wire logic clk_ovr_en_i,
    input wire logic [1:0] clk_ovr_src_i,
    input wire logic [7:0] bp_route_i,
    input wire logic busy_i,
    input wire logic ack1_i,
    input wire logic ack2_i,
    input wire logic block_rcvd_i,
    input wire logic roc_ack_i,
    input wire logic [6:0] status_i,
    input wire logic lat_start_i,
    input wire logic sync_lost_clr_i,
    output logic trig_o,
    output logic trig_fine_o,
    output logic [9:0] trig_type_o,
    output logic content_valid_o,
    output logic [11:0] content_o,
    output logic [7:0] content_seq_o,
    output logic pair_err_o,
    output logic ctrl_valid_o,
    output logic [11:0] ctrl_o,
    output logic sync_lost_o,
    output logic [LAT_W-1:0] lat_cnt_o,
    output logic lat_valid_o,
    output logic master_mode_o,
    output logic [3:0] clk_src_o,
    output logic [7:0] bp_route_o,
    output logic clk31_o,
    output logic tdc_clk_o
);
    typedef struct packed {
        logic [1:0] phase;
        logic [11:0] local_time;
        logic seen_word;
        logic sync_lost;
        logic trig;
        logic trig_fine;
        logic [9:0] trig_type;
        logic dly;
        logic dly_fine;
        logic [9:0] dly_type;
        logic content_valid;
        logic [11:0] content;
        logic [7:0] content_seq;
        logic [7:0] strobe_seq;
        logic pair_err;
        logic ctrl_valid;
        logic [11:0] ctrl;
        logic [15:0] rev_word;
        logic rev_stb;
        tlw_lat_t lat_state;
        logic [LAT_W-1:0] lat_cnt;
        logic [LAT_W-1:0] lat_res;
        logic lat_valid;
        logic lat_tx;
        logic master;
        logic [3:0] clk_src;
        logic [7:0] bp_route;
        logic [1:0] div4;
        logic [1:0] div3;
        logic clk31;
        logic tdc_clk;
    } tlw_crate_st_t;

    tlw_crate_st_t st;
    tlw_crate_st_t next_st;
    logic [1:0] src;
    logic [14:0] stat_body;
    tlw_wtype_t wtype;
    logic [11:0] pay;

    // Unknown route codes fall back to the full-rate clock
    function automatic logic [7:0] tlw_clean_route(input logic [7:0] r);
        logic [7:0] o;
        o = r;
        for (int i = 0; i < 4; i++) begin
            if (r[2*i +: 2] == `TLW_ROUTE_BAD) begin
                o[2*i +: 2] = `TLW_ROUTE_250;
            end
        end
        return o;
    endfunction : tlw_clean_route

    // Source choice, word fields and status body
    assign src = clk_ovr_en_i ? clk_ovr_src_i : clk_switch_i[1:0];
    assign wtype = tlw_wtype_t'(link.fwd_word[`TLW_TYPE_MSB:`TLW_TYPE_LSB]);
    assign pay = link.fwd_word[`TLW_PAY_MSB:0];
    assign stat_body = {`TLW_REV_ZERO, busy_i, ack1_i, ack2_i, block_rcvd_i, roc_ack_i,
        status_i};

    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.trig = 1'b0;
        next_st.content_valid = 1'b0;
        next_st.ctrl_valid = 1'b0;
        next_st.pair_err = 1'b0;
        next_st.rev_stb = 1'b0;
        next_st.lat_valid = 1'b0;

        // Clock selection and derived clocks
        next_st.clk_src = 4'h1 << src;
        next_st.master = (src == `TLW_SRC_OSC) || (src == `TLW_SRC_CABLE);
        next_st.bp_route = tlw_clean_route(bp_route_i);
        next_st.div4 = st.div4 + 1'b1;
        next_st.clk31 = next_st.div4[1];
        next_st.div3 = (st.div3 == `TLW_DIV3_LAST) ? '0 : st.div3 + 1'b1;
        next_st.tdc_clk = (next_st.div3 != `TLW_DIV3_HIGH);

        // Frame phase realigned on every received word
        next_st.phase = st.phase + 1'b1;
        if (st.phase == 2'(`TLW_FRAME_CYC - 1)) begin
            next_st.phase = '0;
            next_st.local_time = st.local_time + 12'(st.seen_word);
            next_st.rev_word = {tlw_parity(stat_body), stat_body};
            next_st.rev_stb = 1'b1;
        end

        // Delayed half of a late-quadrant trigger
        if (st.dly) begin
            next_st.trig = 1'b1;
            next_st.trig_fine = st.dly_fine;
            next_st.trig_type = st.dly_type;
            next_st.dly = 1'b0;
        end

        if (sync_lost_clr_i) begin
            next_st.sync_lost = 1'b0;
        end

        // Word decode
        if (link.fwd_stb) begin
            next_st.phase = 2'h1;
            next_st.seen_word = 1'b1; // Local time runs only once aligned
            unique case (wtype)
                TLW_TIME: begin
                    if (pay != st.local_time) begin
                        next_st.sync_lost = 1'b1;
                    end
                    next_st.local_time = pay;
                end
                TLW_CTRL: begin
                    next_st.ctrl_valid = 1'b1;
                    next_st.ctrl = pay;
                end
                TLW_STROBE: begin
                    next_st.strobe_seq = st.strobe_seq + 1'b1;
                    if (!pay[`TLW_QUAD_MSB]) begin
                        next_st.trig = 1'b1;
                        next_st.trig_fine = pay[0];
                        next_st.trig_type = pay[`TLW_PAY_MSB:`TLW_TTYPE_LSB];
                    end else begin
                        next_st.dly = 1'b1;
                        next_st.dly_fine = pay[0];
                        next_st.dly_type = pay[`TLW_PAY_MSB:`TLW_TTYPE_LSB];
                    end
                end
                TLW_CONTENT: begin
                    next_st.content_valid = 1'b1;
                    next_st.content = pay;
                    next_st.content_seq = st.content_seq + 1'b1;
                    next_st.pair_err = (st.content_seq == st.strobe_seq);
                end
            endcase
        end

        // Lane-four latency probe
        if (st.master) begin
            next_st.lat_tx = link.lat_rx;
            next_st.lat_state = TLW_LAT_IDLE;
        end else begin
            next_st.lat_tx = 1'b0;
            unique case (st.lat_state)
                TLW_LAT_IDLE: begin
                    if (lat_start_i) begin
                        next_st.lat_state = TLW_LAT_SEND;
                    end
                end
                TLW_LAT_SEND: begin
                    next_st.lat_tx = 1'b1;
                    next_st.lat_cnt = '0;
                    next_st.lat_state = TLW_LAT_WAIT;
                end
                TLW_LAT_WAIT: begin
                    next_st.lat_cnt = st.lat_cnt + 1'b1;
                    if (link.lat_rx || (&st.lat_cnt)) begin
                        next_st.lat_res = st.lat_cnt;
                        next_st.lat_valid = 1'b1;
                        next_st.lat_state = TLW_LAT_IDLE;
                    end
                end
                default: begin
                    next_st.lat_state = TLW_LAT_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state; return lanes two and three tied low
    assign link.rev_word = st.rev_word;
    assign link.rev_stb = st.rev_stb;
    assign link.ret_lane2 = 1'b0;
    assign link.ret_lane3 = 1'b0;
    assign link.lat_tx = st.lat_tx;
    assign trig_o = st.trig;
    assign trig_fine_o = st.trig_fine;
    assign trig_type_o = st.trig_type;
    assign content_valid_o = st.content_valid;
    assign content_o = st.content;
    assign content_seq_o = st.content_seq;
    assign pair_err_o = st.pair_err;
    assign ctrl_valid_o = st.ctrl_valid;
    assign ctrl_o = st.ctrl;
    assign sync_lost_o = st.sync_lost;
    assign lat_cnt_o = st.lat_res;
    assign lat_valid_o = st.lat_valid;
    assign master_mode_o = st.master;
    assign clk_src_o = st.clk_src;
    assign bp_route_o = st.bp_route;
    assign clk31_o = st.clk31;
    assign tdc_clk_o = st.tdc_clk;
endmodule : tlw_crate_end
`default_nettype wire

// File: tlw_params.svh
// Shared constants for the trigger link word codec
`ifndef TLW_PARAMS_SVH
`define TLW_PARAMS_SVH
`define TLW_CLK_NS 8
`define TLW_FRAME_NS 16
`define TLW_FRAME_CYC ((`TLW_FRAME_NS + `TLW_CLK_NS - 1) / `TLW_CLK_NS)
`define TLW_TYPE_MSB 13
`define TLW_TYPE_LSB 12
`define TLW_PAY_MSB 11
`define TLW_TTYPE_LSB 2
`define TLW_QUAD_MSB 1
`define TLW_TIME_MSB 13
`define TLW_TIME_LSB 2
`define TLW_TIME_STEP 14'h0004
`define TLW_REV_ZERO 3'h0
`define TLW_SRC_OSC 2'h0
`define TLW_SRC_CABLE 2'h1
`define TLW_ROUTE_BAD 2'h3
`define TLW_ROUTE_250 2'h0
`define TLW_DIV3_LAST 2'h2
`define TLW_DIV3_HIGH 2'h2
`endif

// File: tlw_pkg.sv
// Types and helpers shared by both ends of the trigger link
`include "tlw_params.svh"
package tlw_pkg;
    typedef enum logic [1:0] {
        TLW_TIME = 2'b00,
        TLW_CTRL = 2'b01,
        TLW_STROBE = 2'b10,
        TLW_CONTENT = 2'b11
    } tlw_wtype_t;

    typedef enum logic [1:0] {
        TLW_LAT_IDLE = 2'b00,
        TLW_LAT_SEND = 2'b01,
        TLW_LAT_WAIT = 2'b10
    } tlw_lat_t;

    // Even parity bit: makes the whole 16-bit word carry an even count of ones
    function automatic logic tlw_parity(input logic [14:0] v);
        return ^v;
    endfunction : tlw_parity
endpackage : tlw_pkg

// File: tlw_link_if.sv
// Four-lane fiber link between the fanout module and the crate interface
`timescale 1ns/1ps
`default_nettype none
interface tlw_link_if;
    logic [15:0] fwd_word;
    logic fwd_stb;
    logic [15:0] rev_word;
    logic rev_stb;
    logic clk_lane;
    logic sync_lane;
    logic ret_lane2;
    logic ret_lane3;
    logic lat_tx;
    logic lat_rx;

    modport crate (
        input fwd_word, fwd_stb, clk_lane, sync_lane, lat_rx,
        output rev_word, rev_stb, ret_lane2, ret_lane3, lat_tx
    );
    modport fanout (
        output fwd_word, fwd_stb, clk_lane, sync_lane, lat_rx,
        input rev_word, rev_stb, ret_lane2, ret_lane3, lat_tx
    );
endinterface : tlw_link_if
`default_nettype wire

// File: tlw_fanout_end.sv
// Fanout end: word scheduler, content and control queues, lane-4 loopback
`timescale 1ns/1ps
`default_nettype none
`include "tlw_params.svh"

////////////////////////////////////////////////////////////////////////////////
module tlw_word_fifo import tlw_pkg::*; #(
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic push_i,
    input wire logic [11:0] data_i,
    output logic ready_o,
    input wire logic pop_i,
    output logic [11:0] data_o,
    output logic empty_o
);
    typedef struct packed {
        logic [DEPTH-1:0][11:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] count;
    } tlw_fifo_st_t;

    tlw_fifo_st_t st;
    tlw_fifo_st_t next_st;
    logic do_push;
    logic do_pop;

    // Honest full and empty from the occupancy count
    always_comb begin
        next_st = st;
        do_push = push_i && (st.count != (AW+1)'(DEPTH));
        do_pop = pop_i && (st.count != '0);
        if (do_push) begin
            next_st.mem[st.wp] = data_i;
            next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
        end
        if (do_pop) begin
            next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    // State register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ready_o = (st.count != (AW+1)'(DEPTH));
    assign data_o = st.mem[st.rp];
    assign empty_o = (st.count == '0);
endmodule : tlw_word_fifo

////////////////////////////////////////////////////////////////////////////////
module tlw_fanout_end import tlw_pkg::*; #(
    parameter int DEPTH = 4
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    tlw_link_if.fanout link,
    input wire logic trig_req_i,
    input wire logic [9:0] trig_type_i,
    input wire logic [1:0] trig_quad_i,
    output logic trig_slot_o,
    input wire logic content_valid_i,
    input wire logic [11:0] content_i,
    output logic content_ready_o,
    input wire logic ctrl_valid_i,
    input wire logic [11:0] ctrl_i,
    output logic ctrl_ready_o,
    input wire logic sync_i,
    output logic [15:0] status_o,
    output logic status_valid_o,
    output logic parity_err_o,
    output logic [13:0] master_time_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [1:0] phase;
        logic slot;
        logic [13:0] mtime;
        logic [15:0] fwd_word;
        logic fwd_stb;
        logic clk_lane;
        logic sync_lane;
        logic lat_rx;
        logic [15:0] status;
        logic status_valid;
        logic parity_err;
    } tlw_fan_st_t;

    tlw_fan_st_t st;
    tlw_fan_st_t next_st;
    logic cont_ready;
    logic cont_empty;
    logic [11:0] cont_data;
    logic cont_pop;
    logic ctl_ready;
    logic ctl_empty;
    logic [11:0] ctl_data;
    logic ctl_pop;
    logic frame_go;

    // Content queue, drained only in frames without a strobe
    tlw_word_fifo #(.DEPTH(DEPTH), .AW(AW)) u_content_fifo (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .push_i(content_valid_i),
        .data_i(content_i),
        .ready_o(cont_ready),
        .pop_i(cont_pop),
        .data_o(cont_data),
        .empty_o(cont_empty)
    );

    // Control queue, lowest priority besides time
    tlw_word_fifo #(.DEPTH(DEPTH), .AW(AW)) u_ctrl_fifo (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .push_i(ctrl_valid_i),
        .data_i(ctrl_i),
        .ready_o(ctl_ready),
        .pop_i(ctl_pop),
        .data_o(ctl_data),
        .empty_o(ctl_empty)
    );

    assign frame_go = (st.phase == 2'(`TLW_FRAME_CYC - 1));
    assign cont_pop = frame_go && !(trig_req_i && st.slot) && !cont_empty;
    assign ctl_pop = frame_go && !(trig_req_i && st.slot) && cont_empty && !ctl_empty;

    // Frame scheduler and status receiver
    always_comb begin
        next_st = st;
        next_st.phase = frame_go ? '0 : st.phase + 1'b1;
        next_st.slot = (next_st.phase == 2'(`TLW_FRAME_CYC - 1));
        next_st.fwd_stb = 1'b0;
        next_st.status_valid = 1'b0;
        next_st.clk_lane = ~st.clk_lane;
        next_st.sync_lane = sync_i;
        next_st.lat_rx = link.lat_tx;
        if (frame_go) begin
            next_st.fwd_stb = 1'b1;
            next_st.mtime = st.mtime + `TLW_TIME_STEP;
            if (trig_req_i && st.slot) begin
                // Strobe taken in the slot cycle: latency fixed at one edge
                next_st.fwd_word = {2'b00, TLW_STROBE, trig_type_i, trig_quad_i};
            end else if (!cont_empty) begin
                next_st.fwd_word = {2'b00, TLW_CONTENT, cont_data};
            end else if (!ctl_empty) begin
                next_st.fwd_word = {2'b00, TLW_CTRL, ctl_data};
            end else begin
                next_st.fwd_word = {2'b00, TLW_TIME,
                    st.mtime[`TLW_TIME_MSB:`TLW_TIME_LSB]};
            end
        end
        if (link.rev_stb) begin
            next_st.status = link.rev_word;
            next_st.status_valid = 1'b1;
            next_st.parity_err = (tlw_parity(link.rev_word[14:0]) != link.rev_word[15]);
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.fwd_word = st.fwd_word;
    assign link.fwd_stb = st.fwd_stb;
    assign link.clk_lane = st.clk_lane;
    assign link.sync_lane = st.sync_lane;
    assign link.lat_rx = st.lat_rx;
    assign trig_slot_o = st.slot;
    assign content_ready_o = cont_ready;
    assign ctrl_ready_o = ctl_ready;
    assign status_o = st.status;
    assign status_valid_o = st.status_valid;
    assign parity_err_o = st.parity_err;
    assign master_time_o = st.mtime;
endmodule : tlw_fanout_end
`default_nettype wire

// File: tlw_link_assertions.sv
// Checker for the fiber link joining the fanout end and the crate end
`timescale 1ns/1ps
`default_nettype none
module tlw_link_assertions (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [15:0] fwd_word,
    input wire logic fwd_stb,
    input wire logic [15:0] rev_word,
    input wire logic rev_stb,
    input wire logic ret_lane2,
    input wire logic ret_lane3,
    input wire logic lat_tx,
    input wire logic lat_rx
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);

    ////////////////////////////////////////////////////////////////////////////////
    // Unused return lanes never carry anything
    property p_ret_idle;
        !(ret_lane2 || ret_lane3);
    endproperty
    a_ret_idle: assert property (p_ret_idle) else $error("return lane active");
    // One forward word every two cycles, never closer
    property p_fwd_frame;
        fwd_stb |=> !fwd_stb ##1 fwd_stb;
    endproperty
    a_fwd_frame: assert property (p_fwd_frame) else $error("forward frame spacing");
    // One status word every two cycles
    property p_rev_frame;
        rev_stb |=> !rev_stb ##1 rev_stb;
    endproperty
    a_rev_frame: assert property (p_rev_frame) else $error("reverse frame spacing");
    // Status word only changes with its strobe
    property p_rev_hold;
        !rev_stb |-> $stable(rev_word);
    endproperty
    a_rev_hold: assert property (p_rev_hold) else $error("status word moved");
    // Spare status bits stay clear
    property p_rev_zero;
        rev_stb |-> rev_word[14:12] == 3'h0;
    endproperty
    a_rev_zero: assert property (p_rev_zero) else $error("status spare bits set");
    // Top bit gives even parity over the word
    property p_parity;
        rev_stb |-> rev_word[15] == ^rev_word[14:0];
    endproperty
    a_parity: assert property (p_parity) else $error("status parity wrong");
    // Probe pulse comes back one cycle later
    property p_loop;
        $rose(lat_tx) |=> lat_rx;
    endproperty
    a_loop: assert property (p_loop) else $error("probe not looped");
    // Back-to-back time words count up by one
    property p_time;
        fwd_stb && fwd_word[13:12] == 2'h0 && $past(fwd_stb, 2)
            && $past(fwd_word[13:12], 2) == 2'h0
            |-> fwd_word[11:0] == $past(fwd_word[11:0], 2) + 12'h001;
    endproperty
    a_time: assert property (p_time) else $error("time word step wrong");
endmodule : tlw_link_assertions
`default_nettype wire

// File: tb_trigger_link_word_codec.sv
// Self-checking bench joining the fanout end and the crate end
`timescale 1ns/1ps
`default_nettype none
module tb_trigger_link_word_codec;
    logic clock_i, arst_n_i, trig_req_i, content_valid_i, ctrl_valid_i, sync_i;
    logic clk_ovr_en_i, lat_start_i, sync_lost_clr_i, busy_i, ack1_i, ack2_i;
    logic block_rcvd_i, roc_ack_i;
    logic pair_seen = 1'b0;
    logic [9:0] trig_type_i, trig_type_o;
    logic [1:0] trig_quad_i, clk_ovr_src_i;
    logic [11:0] content_i, ctrl_i, content_o, ctrl_o, lat_cnt_o;
    logic [7:0] clk_switch_i, bp_route_i, content_seq_o, bp_route_o;
    logic [13:0] master_time_o;
    logic [6:0] status_i;
    logic [15:0] status_o, mt;
    logic [3:0] clk_src_o;
    logic trig_slot_o, content_ready_o, ctrl_ready_o, status_valid_o, parity_err_o;
    logic trig_o, trig_fine_o, content_valid_o, pair_err_o, ctrl_valid_o, sync_lost_o;
    logic lat_valid_o, master_mode_o, clk31_o, tdc_clk_o;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int n, h31, htdc;
    // Status inputs: busy, ack1, ack2, block, readout ack, general status
    logic [11:0] st_rows [5] = '{12'h800, 12'h400, 12'h2A5, 12'hFFF, 12'h181};

    tlw_link_if link ();
    tlw_fanout_end i_tlw_fanout_end (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .link(link.fanout), .trig_req_i(trig_req_i), .trig_type_i(trig_type_i),
        .trig_quad_i(trig_quad_i), .trig_slot_o(trig_slot_o),
        .content_valid_i(content_valid_i), .content_i(content_i),
        .content_ready_o(content_ready_o), .ctrl_valid_i(ctrl_valid_i), .ctrl_i(ctrl_i),
        .ctrl_ready_o(ctrl_ready_o), .sync_i(sync_i), .status_o(status_o),
        .status_valid_o(status_valid_o), .parity_err_o(parity_err_o),
        .master_time_o(master_time_o));
    tlw_crate_end i_tlw_crate_end (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .link(link.crate), .clk_switch_i(clk_switch_i), .clk_ovr_en_i(clk_ovr_en_i),
        .clk_ovr_src_i(clk_ovr_src_i), .bp_route_i(bp_route_i), .busy_i(busy_i),
        .ack1_i(ack1_i), .ack2_i(ack2_i), .block_rcvd_i(block_rcvd_i),
        .roc_ack_i(roc_ack_i), .status_i(status_i), .lat_start_i(lat_start_i),
        .sync_lost_clr_i(sync_lost_clr_i), .trig_o(trig_o), .trig_fine_o(trig_fine_o),
        .trig_type_o(trig_type_o), .content_valid_o(content_valid_o),
        .content_o(content_o), .content_seq_o(content_seq_o), .pair_err_o(pair_err_o),
        .ctrl_valid_o(ctrl_valid_o), .ctrl_o(ctrl_o), .sync_lost_o(sync_lost_o),
        .lat_cnt_o(lat_cnt_o), .lat_valid_o(lat_valid_o), .master_mode_o(master_mode_o),
        .clk_src_o(clk_src_o), .bp_route_o(bp_route_o), .clk31_o(clk31_o),
        .tdc_clk_o(tdc_clk_o));
    tlw_link_assertions i_tlw_link_assertions (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .fwd_word(link.fwd_word), .fwd_stb(link.fwd_stb), .rev_word(link.rev_word),
        .rev_stb(link.rev_stb), .ret_lane2(link.ret_lane2), .ret_lane3(link.ret_lane3),
        .lat_tx(link.lat_tx), .lat_rx(link.lat_rx));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 125 MHz
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // Cycle ceiling and sticky record of pairing errors
    always @(posedge clock_i) begin
        cyc++;
        if (pair_err_o === 1'b1) pair_seen <= 1'b1;
        if (cyc == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tick();
        @(posedge clock_i);
        #1;
    endtask : tick

    // Waits, bounded, until a flag is seen high just after an edge
    task automatic wait_hi(ref logic s);
        int k;
        k = 0;
        do begin
            tick();
            k++;
        end while (s !== 1'b1 && k < 200);
        if (s !== 1'b1) chk("wait", 16'h1, 16'h0);
    endtask : wait_hi

    // Queue push: held until taken at an edge with ready high
    task automatic push(ref logic v, ref logic [11:0] d, ref logic rdy, input logic [11:0] x);
        d = x;
        v = 1'b1;
        while (rdy !== 1'b1) tick();
        tick();
        v = 1'b0;
    endtask : push

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {arst_n_i, trig_req_i, content_valid_i, ctrl_valid_i, sync_i, clk_ovr_en_i} = '0;
        {lat_start_i, sync_lost_clr_i, busy_i, ack1_i, ack2_i, block_rcvd_i, roc_ack_i} = '0;
        {trig_type_i, trig_quad_i, clk_ovr_src_i, content_i, ctrl_i, status_i} = '0;
        clk_switch_i = 8'h02;
        bp_route_i = 8'h1B;
        repeat (3) @(posedge clock_i);
        #1;
        chk("outputs in reset", 16'h0, {11'h0, trig_o, content_valid_o, ctrl_valid_o,
            lat_valid_o, sync_lost_o});
        arst_n_i = 1'b1;
        // Status word rows
        foreach (st_rows[k]) begin
            {busy_i, ack1_i, ack2_i, block_rcvd_i, roc_ack_i, status_i} = st_rows[k];
            wait_hi(status_valid_o);
            wait_hi(status_valid_o);
            chk("status_o", {^st_rows[k], 3'h0, st_rows[k]}, status_o);
            chk("parity_err_o", 16'h0, {15'h0, parity_err_o});
        end
        // Strobes in every quadrant
        for (int q = 0; q < 4; q++) begin
            wait_hi(trig_slot_o);
            trig_type_i = {8'h5A, 2'(q)};
            trig_quad_i = 2'(q);
            trig_req_i = 1'b1;
            tick();
            trig_req_i = 1'b0;
            n = 0;
            while (trig_o !== 1'b1 && n < 9) begin
                tick();
                n++;
            end
            chk("trig delay", 16'(1 + q / 2), 16'(n));
            chk("trig_fine_o", 16'(q % 2), {15'h0, trig_fine_o});
            chk("trig_type_o", {6'h0, 8'h5A, 2'(q)}, {6'h0, trig_type_o});
        end
        // Contents pair in order; the fifth has no strobe left
        for (int k = 1; k <= 5; k++) begin
            push(content_valid_i, content_i, content_ready_o, 12'hC00 + 12'(k));
            wait_hi(content_valid_o);
            chk("content_o", 16'hC00 + 16'(k), {4'h0, content_o});
            if (k < 5) chk("content_seq_o", 16'(k), {8'h0, content_seq_o});
            tick();
            chk("pair_err_o", 16'(k / 5), {15'h0, pair_seen});
        end
        push(ctrl_valid_i, ctrl_i, ctrl_ready_o, 12'h5A3);
        wait_hi(ctrl_valid_o);
        chk("ctrl_o", 16'h05A3, {4'h0, ctrl_o});
        // Latency probe in standard mode
        chk("clk_src_o", 16'h0004, {12'h0, clk_src_o});
        lat_start_i = 1'b1;
        tick();
        lat_start_i = 1'b0;
        wait_hi(lat_valid_o);
        chk("lat_cnt_o", 16'h0001, {4'h0, lat_cnt_o});
        // Software override to cable source: local master, probe refused
        clk_ovr_en_i = 1'b1;
        clk_ovr_src_i = 2'h1;
        repeat (3) tick();
        chk("clk_src_o", 16'h0002, {12'h0, clk_src_o});
        chk("master_mode_o", 16'h1, {15'h0, master_mode_o});
        lat_start_i = 1'b1;
        n = 0;
        repeat (20) begin
            tick();
            lat_start_i = 1'b0;
            if (lat_valid_o !== 1'b0) n++;
        end
        chk("probe in master mode", 16'h0, 16'(n));
        // Derived clock duty over twelve cycles
        h31 = 0;
        htdc = 0;
        repeat (12) begin
            tick();
            if (clk31_o === 1'b1) h31++;
            if (tdc_clk_o === 1'b1) htdc++;
        end
        chk("clk31_o high", 16'h6, 16'(h31));
        chk("tdc_clk_o high", 16'h8, 16'(htdc));
        chk("sync_lost_o", 16'h0, {15'h0, sync_lost_o});
        chk("bp_route_o", 16'h0018, {8'h0, bp_route_o});
        // Master time steps by four per frame
        wait_hi(trig_slot_o);
        mt = {2'h0, master_time_o};
        wait_hi(trig_slot_o);
        chk("master_time_o", mt + 16'h0004, {2'h0, master_time_o});
        complete_run();
    end
endmodule : tb_trigger_link_word_codec
`default_nettype wire
